// ---- src/dls_pkg.sv ----
// Constants, carrier types and state codes of the dual head supply status block
//
// Notes on behaviour
// - Thermal and supply flags latch until a read finds their cause gone.
// - Output-off flag sets on fault or disable; clears when commanded on.
// - Power-bad, tone-seen, cable-open flags clear by themselves.
// - A multi-byte read alternates fault_status and line_status.
// - Each new read transaction starts with fault_status.
// - Both outputs on and no condition present gives all status bits zero.
// - fault_status bits 0-7: off1 off2 oc1 oc2 bad1 bad2 thermal supply.
// - line_status bits 0-3: cable1, cable2, tone1, tone2; bits 4-7 unused.
// - Off flags set at power-on and on fault, never raising the interrupt.
// - End of a write leaving an output enabled clears its output-off flag if no thermal, supply or timed oc flag is set.
// - Overcurrent beyond 48 ms turns output off, sets oc and off flags.
// - Ninth read clock rise updates status; timed oc flag clears there.
// - Timer off: oc flag follows the overcurrent, output stays limited.
// - Overheat turns outputs off; thermal flag clears at sample if gone.
// - Supply low: both off until rewritten; flag clears at sample if gone.
// - Power-bad sets below 85 percent of level, clears within 90 percent.
// - Power-bad reads one while the output is off, also after power-up.
// - In cable test, cable-open sets above 21 V and clears below 19.95 V.
package dls_pkg;

    localparam int          CLK_HZ        = 25_000_000;
    localparam int          OCP_TIME_MS   = 48;
    localparam int          OCP_CYCLES    = (CLK_HZ / 1000) * OCP_TIME_MS;
    // Arbitrary default bus address
    localparam logic [6:0]  DEV_ADDR_DEF  = 7'h08;

    localparam int          FS_OFF_POS    = 0;
    localparam int          FS_OC_POS     = 2;
    localparam int          FS_BAD_POS    = 4;
    localparam int          FS_THERM_POS  = 6;
    localparam int          FS_SUPPLY_POS = 7;
    localparam int          LS_CABLE_POS  = 0;
    localparam int          LS_TONE_POS   = 2;

    localparam int          CTRL_BANK_BIT  = 7;
    localparam int          CTRL_CH_BIT    = 6;
    localparam int          CTRL_EN_BIT    = 5;
    localparam int          CTRL_TIMER_BIT = 4;
    localparam int          CTRL_CABLE_BIT = 2;

    localparam logic [1:0]  OFF_RST       = 2'h3;
    localparam logic [1:0]  BAD_RST       = 2'h3;
    localparam logic        EN_RST        = 1'h0;
    localparam logic        TIMER_EN_RST  = 1'h1;
    localparam logic        CABLE_RST     = 1'h0;
    localparam logic [2:0]  BYTE_LAST_BIT = 3'h7;

    typedef struct packed {
        logic [1:0] oc;
        logic       thermal;
        logic       supply_low;
        logic [1:0] below85;
        logic [1:0] within90;
        logic [1:0] above21;
        logic [1:0] below1995;
        logic [1:0] tone;
    } dls_sense_type;

    typedef struct packed {
        logic en;
        logic timer_en;
        logic cable_test;
    } dls_ctrl_type;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_ADDR      = 3'b001,
        ST_ADDR_ACK  = 3'b010,
        ST_WRITE     = 3'b011,
        ST_WRITE_ACK = 3'b100,
        ST_READ      = 3'b101,
        ST_READ_ACK  = 3'b110,
        ST_WAIT      = 3'b111
    } dls_state_type;

endpackage

// ---- src/dls_sync.sv ----
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module dls_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= INIT;
            q_out  <= INIT;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end

endmodule
`default_nettype wire

// ---- src/dls_oc_timer.sv ----
// Overcurrent persistence timer for one output channel
`timescale 1ns/100ps
`default_nettype none
module dls_oc_timer
    import dls_pkg::*;
#(
    parameter int CYCLES = OCP_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic active_in,
    output logic      trip_out
);

    localparam int         W    = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] count_r;

    // Any gap in the overcurrent restarts the count
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r  <= '0;
            trip_out <= 1'b0;
        end else if (!active_in) begin
            count_r  <= '0;
            trip_out <= 1'b0;
        end else if (count_r == LAST) begin
            count_r  <= '0;
            trip_out <= 1'b1;
        end else begin
            count_r  <= count_r + 1'b1;
            trip_out <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- src/dls_status_regs.sv ----
// Two-wire status and control slave of the dual head supply regulator
`timescale 1ns/100ps
`default_nettype none
module dls_status_regs
    import dls_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR     = DEV_ADDR_DEF,
    parameter int         OCP_CYCLES_P = OCP_CYCLES
) (
    input  wire logic          clk_sys_in,
    input  wire logic          resetn_in,
    input  wire logic          scl_in,
    input  wire logic          sda_in,
    output logic               sda_out,
    output logic               sda_oe_out,
    input  wire dls_sense_type sense_in,
    output logic [1:0]         output_on_out,
    output logic [1:0]         cable_test_out,
    output logic               irq_out
);

    logic [1:0]    rst_sync_r;
    logic          rst_n;
    logic [1:0]    pin_s;
    logic          scl_s;
    logic          sda_s;
    dls_sense_type sense_s;
    logic          scl_d_r;
    logic          sda_d_r;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_det;
    logic          stop_det;

    dls_state_type state_r;
    dls_state_type state_nxt;
    logic [2:0]    bit_cnt_r;
    logic [2:0]    bit_cnt_nxt;
    logic [7:0]    shift_r;
    logic [7:0]    shift_nxt;
    logic [7:0]    tx_r;
    logic [7:0]    tx_nxt;
    logic          reg_sel_r;
    logic          reg_sel_nxt;
    logic          wrote_r;
    logic          wrote_nxt;
    logic          sda_oe_nxt;
    logic          wr_byte_stb;
    logic [7:0]    wr_byte;
    logic          read_sample;
    logic          write_end;

    dls_ctrl_type  ctrl_r [2];
    logic [1:0]    oc_trip;
    logic [1:0]    off_r;
    logic [1:0]    off_nxt;
    logic [1:0]    oc_flag_r;
    logic [1:0]    oc_flag_nxt;
    logic [1:0]    bad_r;
    logic [1:0]    bad_nxt;
    logic [1:0]    cable_r;
    logic [1:0]    cable_nxt;
    logic [1:0]    tone_r;
    logic          thermal_r;
    logic          thermal_nxt;
    logic          supply_r;
    logic          supply_nxt;
    logic [3:0]    fault_vec_r;
    logic [3:0]    fault_vec_nxt;
    logic          irq_nxt;
    logic [7:0]    fault_status;
    logic [7:0]    line_status;

    // Release of reset is aligned to the system clock
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    dls_sync #(
        .WIDTH (2),
        .INIT  (2'h3)
    ) u_pin_sync (
        .clk_in   (clk_sys_in),
        .rst_n_in (rst_n),
        .d_in     ({scl_in, sda_in}),
        .q_out    (pin_s)
    );
    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];

    dls_sync #(
        .WIDTH ($bits(dls_sense_type)),
        .INIT  ('0)
    ) u_sense_sync (
        .clk_in   (clk_sys_in),
        .rst_n_in (rst_n),
        .d_in     (sense_in),
        .q_out    (sense_s)
    );

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign wr_byte   = {shift_r[6:0], sda_s};

    // Bus protocol: bits taken on SCL rise, driven on SCL fall
    always_comb begin
        state_nxt   = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt   = shift_r;
        tx_nxt      = tx_r;
        reg_sel_nxt = reg_sel_r;
        wrote_nxt   = wrote_r;
        sda_oe_nxt  = sda_oe_out;
        wr_byte_stb = 1'b0;
        read_sample = 1'b0;
        write_end   = 1'b0;
        if (start_det || stop_det) begin
            write_end   = wrote_r;
            wrote_nxt   = 1'b0;
            bit_cnt_nxt = 3'h0;
            sda_oe_nxt  = 1'b0;
            reg_sel_nxt = 1'b0;
            state_nxt   = start_det ? ST_ADDR : ST_IDLE;
        end else if (scl_rise) begin
            case (state_r)
                ST_ADDR: begin
                    shift_nxt   = wr_byte;
                    bit_cnt_nxt = bit_cnt_r + 3'h1;
                    if (bit_cnt_r == BYTE_LAST_BIT) begin
                        if (shift_r[6:0] == DEV_ADDR) begin
                            state_nxt = ST_ADDR_ACK;
                        end else begin
                            state_nxt = ST_WAIT;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (shift_r[0]) begin
                        state_nxt   = ST_READ;
                        tx_nxt      = fault_status;
                        reg_sel_nxt = 1'b0;
                    end else begin
                        state_nxt = ST_WRITE;
                        wrote_nxt = 1'b1;
                    end
                end
                ST_WRITE: begin
                    shift_nxt   = wr_byte;
                    bit_cnt_nxt = bit_cnt_r + 3'h1;
                    if (bit_cnt_r == BYTE_LAST_BIT) begin
                        state_nxt   = ST_WRITE_ACK;
                        wr_byte_stb = 1'b1;
                    end
                end
                ST_WRITE_ACK: begin
                    state_nxt = ST_WRITE;
                end
                ST_READ: begin
                    tx_nxt      = {tx_r[6:0], 1'b0};
                    bit_cnt_nxt = bit_cnt_r + 3'h1;
                    if (bit_cnt_r == BYTE_LAST_BIT) begin
                        state_nxt = ST_READ_ACK;
                    end
                end
                ST_READ_ACK: begin
                    read_sample = 1'b1;
                    if (!sda_s) begin
                        state_nxt   = ST_READ;
                        reg_sel_nxt = ~reg_sel_r;
                        tx_nxt      = reg_sel_r ? fault_status : line_status;
                    end else begin
                        state_nxt = ST_WAIT;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_r)
                ST_ADDR_ACK,
                ST_WRITE_ACK: sda_oe_nxt = 1'b1;
                ST_READ:      sda_oe_nxt = ~tx_r[7];
                default:      sda_oe_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= ST_IDLE;
            bit_cnt_r  <= 3'h0;
            shift_r    <= 8'h00;
            tx_r       <= 8'h00;
            reg_sel_r  <= 1'b0;
            wrote_r    <= 1'b0;
            sda_oe_out <= 1'b0;
            sda_out    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            bit_cnt_r  <= bit_cnt_nxt;
            shift_r    <= shift_nxt;
            tx_r       <= tx_nxt;
            reg_sel_r  <= reg_sel_nxt;
            wrote_r    <= wrote_nxt;
            sda_oe_out <= sda_oe_nxt;
            sda_out    <= 1'b0;
        end
    end

    // Control bytes: bit 7 picks the bank, bit 6 the channel
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                ctrl_r[i] <= '{EN_RST, TIMER_EN_RST, CABLE_RST};
            end
        end else if (wr_byte_stb) begin
            if (!wr_byte[CTRL_BANK_BIT]) begin
                ctrl_r[wr_byte[CTRL_CH_BIT]].en <= wr_byte[CTRL_EN_BIT];
                ctrl_r[wr_byte[CTRL_CH_BIT]].timer_en <=
                    wr_byte[CTRL_TIMER_BIT];
            end else begin
                ctrl_r[wr_byte[CTRL_CH_BIT]].cable_test <=
                    wr_byte[CTRL_CABLE_BIT];
            end
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_timer
        dls_oc_timer #(
            .CYCLES (OCP_CYCLES_P)
        ) u_timer (
            .clk_in    (clk_sys_in),
            .rst_n_in  (rst_n),
            .active_in (ctrl_r[g].timer_en & sense_s.oc[g] & ~off_r[g]),
            .trip_out  (oc_trip[g])
        );
    end

    // Flag next values; a set always beats a clear in the same cycle
    always_comb begin
        thermal_nxt = sense_s.thermal | (thermal_r & ~read_sample);
        supply_nxt  = sense_s.supply_low
                    | (supply_r & ~read_sample);
        for (int i = 0; i < 2; i++) begin
            if (ctrl_r[i].timer_en) begin
                oc_flag_nxt[i] = oc_trip[i]
                               | (oc_flag_r[i] & ~read_sample);
            end else begin
                oc_flag_nxt[i] = sense_s.oc[i];
            end
            off_nxt[i] = oc_trip[i] | sense_s.thermal | sense_s.supply_low
                       | ~ctrl_r[i].en
                       | (off_r[i] & ~(write_end & ctrl_r[i].en & ~thermal_r
                                       & ~supply_r
                                       & ~(ctrl_r[i].timer_en
                                           & oc_flag_r[i])));
            bad_nxt[i] = off_r[i] | sense_s.below85[i]
                       | (bad_r[i] & ~sense_s.within90[i]);
            cable_nxt[i] = ctrl_r[i].cable_test
                         & (sense_s.above21[i]
                            | (cable_r[i] & ~sense_s.below1995[i]));
        end
        // Output-off flags stay out of this vector on purpose
        fault_vec_nxt = {supply_nxt, thermal_nxt, oc_flag_nxt};
        irq_nxt = (|(fault_vec_nxt & ~fault_vec_r))
                | (irq_out & ~(read_sample & ~(|fault_vec_nxt)));
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            off_r         <= OFF_RST;
            output_on_out <= 2'h0;
            oc_flag_r     <= 2'h0;
            thermal_r     <= 1'b0;
            supply_r      <= 1'b0;
        end else begin
            off_r         <= off_nxt;
            output_on_out <= ~off_nxt;
            oc_flag_r     <= oc_flag_nxt;
            thermal_r     <= thermal_nxt;
            supply_r      <= supply_nxt;
        end
    end

    // Live flags need no read to clear
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            bad_r   <= BAD_RST;
            cable_r <= 2'h0;
            tone_r  <= 2'h0;
        end else begin
            bad_r   <= bad_nxt;
            cable_r <= cable_nxt;
            tone_r  <= sense_s.tone;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            fault_vec_r    <= 4'h0;
            irq_out        <= 1'b0;
            cable_test_out <= 2'h0;
        end else begin
            fault_vec_r    <= fault_vec_nxt;
            irq_out        <= irq_nxt;
            cable_test_out <= {ctrl_r[1].cable_test, ctrl_r[0].cable_test};
        end
    end

    // All-clear operation reads as zero in both bytes
    always_comb begin
        fault_status                           = 8'h00;
        fault_status[FS_OFF_POS +: 2]          = off_r;
        fault_status[FS_OC_POS +: 2]           = oc_flag_r;
        fault_status[FS_BAD_POS +: 2]          = bad_r;
        fault_status[FS_THERM_POS]             = thermal_r;
        fault_status[FS_SUPPLY_POS]            = supply_r;
        line_status                            = 8'h00;
        line_status[LS_CABLE_POS +: 2]         = cable_r;
        line_status[LS_TONE_POS +: 2]          = tone_r;
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n);

    thermal_hold_a: assert property (
        thermal_r && !read_sample |=> thermal_r)
        else $error("thermal flag dropped without a read");
    off_hold_a: assert property (
        off_r[0] && !write_end |=> off_r[0])
        else $error("output-off flag cleared outside a write end");
    tone_live_a: assert property (
        !sense_s.tone[0] |=> !tone_r[0])
        else $error("tone flag stuck after tone gone");
    reg_alternate_a: assert property (
        read_sample && !sda_s |=> reg_sel_r != $past(reg_sel_r))
        else $error("read registers did not alternate");
    read_first_a: assert property (
        state_r == ST_ADDR_ACK && scl_rise && shift_r[0]
        |=> tx_r == $past(fault_status) && !reg_sel_r)
        else $error("read did not start with fault status");
    oc_trip_a: assert property (
        oc_trip[0] |=> oc_flag_r[0] && off_r[0] && !output_on_out[0])
        else $error("overcurrent trip not reported");
    thermal_off_a: assert property (
        sense_s.thermal |=> thermal_r && off_r == 2'h3)
        else $error("overtemperature did not switch outputs off");
    supply_keep_a: assert property (
        supply_r && sense_s.supply_low |=> supply_r)
        else $error("supply-low flag cleared while low");
    bad_when_off_a: assert property (
        off_r[1] |=> bad_r[1])
        else $error("power-bad not set while output off");
    irq_raise_a: assert property (
        $rose(thermal_r) |-> irq_out ##1 (irq_out || read_sample))
        else $error("interrupt missing on new fault");
    line_upper_a: assert property (
        line_status[7:4] == 4'h0)
        else $error("unused line status bits not zero");

    two_byte_read_c: cover property (
        read_sample && !sda_s ##[1:1000] read_sample);
    write_enable_c: cover property (write_end && $fell(off_r[0]));
    oc_trip_c: cover property (oc_trip[0]);

endmodule
`default_nettype wire

// ---- testbench/dls_master_model.sv ----
// Two-wire bus master model driving the status block
`timescale 1ns/100ps
`default_nettype none
module dls_master_model
    import dls_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out
);
    // Quarter bit length in clocks; raised to model a slow master
    int q_len = 10;
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // A released line floats to the pull-up, never a stale level
    task automatic bit_io(input logic b, output logic r);
        sda_out <= b;
        tick(q_len);
        scl_out <= 1'b1;
        tick(q_len);
        r = sda_in;
        tick(q_len);
        scl_out <= 1'b0;
        tick(q_len);
    endtask
    task automatic start();
        sda_out <= 1'b1;
        tick(q_len);
        scl_out <= 1'b1;
        tick(q_len);
        sda_out <= 1'b0;
        tick(q_len);
        scl_out <= 1'b0;
        tick(q_len);
    endtask
    task automatic stop();
        sda_out <= 1'b0;
        tick(q_len);
        scl_out <= 1'b1;
        tick(q_len);
        sda_out <= 1'b1;
        tick(q_len);
    endtask
    task automatic byte_io(input logic [7:0] d, input logic ack,
                           output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(ack, r);
    endtask
    task automatic write_ctrl(input logic [7:0] c1, input logic [7:0] c2);
        logic [7:0] q;
        start();
        byte_io({DEV_ADDR_DEF, 1'b0}, 1'b1, q);
        byte_io(c1, 1'b1, q);
        byte_io(c2, 1'b1, q);
        stop();
    endtask
    // Acks every byte but the last; newest byte lands in the low bits
    task automatic read_n(input int n, output logic [31:0] d);
        logic [7:0] q;
        d = '0;
        start();
        byte_io({DEV_ADDR_DEF, 1'b1}, 1'b1, q);
        for (int k = 0; k < n; k++) begin
            byte_io(8'hFF, k == n - 1, q);
            d = {d[23:0], q};
        end
        stop();
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the dual head supply status block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dls_pkg::*;
    logic          clk_sys = 1'b0;
    logic          resetn = 1'b0;
    dls_sense_type sense = '0;
    logic          scl;
    logic          sda_m;
    logic          sda_oe;
    logic          sda_o;
    logic [1:0]    out_on;
    logic [1:0]    cab;
    logic          irq;
    logic [31:0]   d;
    int            error_cnt = 0;
    int            samples_checked = 0;
    wire logic     sda = sda_m & ~sda_oe;
    always #20 clk_sys = ~clk_sys;
    dls_status_regs #(.OCP_CYCLES_P(20)) dls_status_regs_inst (
        .clk_sys_in(clk_sys), .resetn_in(resetn), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .sense_in(sense),
        .output_on_out(out_on), .cable_test_out(cab), .irq_out(irq));
    dls_master_model dls_master_model_inst (
        .clk_in(clk_sys), .sda_in(sda), .scl_out(scl), .sda_out(sda_m));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        dls_master_model_inst.tick(n);
    endtask
    task automatic rd(input int n);
        dls_master_model_inst.read_n(n, d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] b);
        dls_master_model_inst.write_ctrl(a, b);
        wt(4);
    endtask
    task automatic t_reset();
        rd(2);
        check(d[15:8], 8'h33);
        check(d[7:0], 8'h00);
        rd(3);
        check(d[23:16], 8'h33);
        check(d[7:0], 8'h33);
        check({6'h00, out_on}, 8'h00);
        check({7'h00, sda_o}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_enable();
        sense.within90 <= 2'h3;
        wr(8'h30, 8'h70);
        check({6'h00, out_on}, 8'h03);
        rd(2);
        check(d[15:8], 8'h00);
        check(d[7:0], 8'h00);
        $display("test enable done");
    endtask
    task automatic t_line();
        wr(8'h84, 8'hC4);
        check({6'h00, cab}, 8'h03);
        sense.tone <= 2'h2;
        sense.above21 <= 2'h1;
        wt(10);
        rd(2);
        check(d[7:0], 8'h09);
        sense.tone <= 2'h0;
        sense.above21 <= 2'h0;
        sense.below1995 <= 2'h1;
        wt(10);
        rd(2);
        check(d[7:0], 8'h00);
        $display("test line done");
    endtask
    // Fault hits both channels; the cause ends before the first read
    task automatic t_fault(input logic k);
        dls_master_model_inst.q_len = k ? 20 : 10;
        sense.thermal <= ~k;
        sense.supply_low <= k;
        wt(10);
        check({7'h00, irq}, 8'h01);
        check({6'h00, out_on}, 8'h00);
        sense.thermal <= 1'b0;
        sense.supply_low <= 1'b0;
        wt(10);
        rd(1);
        check(d[7:0], k ? 8'hB3 : 8'h73);
        rd(1);
        check(d[7:0], 8'h33);
        check({6'h00, out_on}, 8'h00);
        check({7'h00, irq}, 8'h00);
        wr(8'h30, 8'h70);
        rd(1);
        check(d[7:0], 8'h00);
        $display("test fault done");
    endtask
    task automatic t_oc();
        dls_master_model_inst.q_len = 10;
        sense.oc <= 2'h1;
        wt(40);
        check({6'h00, out_on}, 8'h02);
        sense.oc <= 2'h0;
        wt(10);
        rd(1);
        check(d[7:0], 8'h15);
        rd(1);
        check(d[7:0], 8'h11);
        wr(8'h20, 8'h70);
        sense.oc <= 2'h1;
        wt(40);
        rd(1);
        check(d[7:0], 8'h04);
        sense.oc <= 2'h0;
        wt(10);
        rd(1);
        check(d[7:0], 8'h00);
        $display("test overcurrent done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        wt(10);
        t_reset();
        t_enable();
        t_line();
        t_fault(1'b0);
        t_fault(1'b1);
        t_oc();
        results();
    end
    // Whole run needs about 23400 clocks
    initial begin
        repeat (90000) @(posedge clk_sys);
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire
